// File: adcie_cfg.svh
// register offsets, field positions, reset values and sizes of the interrupt enable bank
`ifndef ADCIE_CFG_SVH
`define ADCIE_CFG_SVH

`define ADCIE_ADDR_W 12
`define ADCIE_DATA_W 32
`define ADCIE_NUM_EVENTS 22

`define ADCIE_OFF_ENABLE 12'h300
`define ADCIE_OFF_ENABLE_SET 12'h304
`define ADCIE_OFF_STATUS 12'h100
`define ADCIE_OFF_STATUS_CLR 12'h104

`define ADCIE_BIT_STARTED 0
`define ADCIE_BIT_STOPPED 5
`define ADCIE_BIT_CH0_UPPER 6
`define ADCIE_BIT_CH6_UPPER 18
`define ADCIE_BIT_CH6_LOWER 19
`define ADCIE_BIT_CH7_UPPER 20
`define ADCIE_BIT_CH7_LOWER 21

`define ADCIE_ENABLE_RST 22'h0
`define ADCIE_STATUS_RST 22'h0
`define ADCIE_RDATA_RST 32'h0

`endif

// File: adcie_pkg.sv
// types shared by the interrupt enable bank modules
`include "adcie_cfg.svh"

package adcie_pkg;

    typedef logic [`ADCIE_NUM_EVENTS-1:0] adcie_evt_vec_t;

    typedef struct packed {
        adcie_evt_vec_t enable;
        logic irq;
        logic [`ADCIE_DATA_W-1:0] rdata;
    } adcie_main_state_t;

    typedef struct packed {
        adcie_evt_vec_t status;
    } adcie_stat_state_t;

endpackage

// File: adcie_evt_if.sv
// carrier between the register front end and the sticky event status bank
`timescale 1ns/1ps

interface adcie_evt_if;
    adcie_pkg::adcie_evt_vec_t evt;
    adcie_pkg::adcie_evt_vec_t clr;
    adcie_pkg::adcie_evt_vec_t status;

    modport bank (
        input evt,
        input clr,
        output status
    );

    modport ctrl (
        output evt,
        output clr,
        input status
    );
endinterface

// File: adcie_stat_bank.sv
// sticky per-event status bits, set by event pulses, cleared by software
`timescale 1ns/1ps
`include "adcie_cfg.svh"

module adcie_stat_bank (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // event and clear traffic
    adcie_evt_if.bank evt_bus
);

    adcie_pkg::adcie_stat_state_t st;
    adcie_pkg::adcie_stat_state_t next_st;

    always_comb begin
        next_st = st;
        // a pulse in the clearing cycle still lands: set beats clear
        for (int i = 0; i < `ADCIE_NUM_EVENTS; i++) begin
            if (evt_bus.evt[i]) begin
                next_st.status[i] = 1'b1;
            end else if (evt_bus.clr[i]) begin
                next_st.status[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st.status <= `ADCIE_STATUS_RST;
        end else begin
            st <= next_st;
        end
    end

    assign evt_bus.status = st.status;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    a_set_beats_clear: assert property (
        (evt_bus.evt != '0) |=> ((st.status & $past(evt_bus.evt)) == $past(evt_bus.evt)))
        else $error("event pulse lost in status bank");

    a_clear_takes_bit: assert property (
        ((evt_bus.clr & ~evt_bus.evt) != '0)
        |=> ((st.status & $past(evt_bus.clr & ~evt_bus.evt)) == '0))
        else $error("status bit survived a clear");

endmodule

// File: adcie_enable_regs.sv
// interrupt enable register bank of the converter: plain and set-only views
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "adcie_cfg.svh"

module adcie_enable_regs (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // register port
    input wire logic [`ADCIE_ADDR_W-1:0] i_addr,
    input wire logic [`ADCIE_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`ADCIE_DATA_W-1:0] o_rdata,
    // converter events, one-cycle pulses
    input wire logic [`ADCIE_NUM_EVENTS-1:0] i_event,
    // interrupt
    output logic o_irq
);

    localparam int PAD_W = `ADCIE_DATA_W - `ADCIE_NUM_EVENTS;

    adcie_pkg::adcie_main_state_t st;
    adcie_pkg::adcie_main_state_t next_st;
    adcie_pkg::adcie_evt_vec_t wr_bits;
    adcie_pkg::adcie_evt_vec_t next_clr;

    adcie_evt_if evt_bus ();

    adcie_stat_bank u_stat_bank (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .evt_bus(evt_bus.bank)
    );

    // bits above the event field are ignored on write, read as zero
    assign wr_bits = i_wdata[`ADCIE_NUM_EVENTS-1:0];

    always_comb begin
        next_st = st;
        next_clr = '0;
        next_st.rdata = `ADCIE_RDATA_RST;
        if (i_wr) begin
            case (i_addr)
                `ADCIE_OFF_ENABLE: begin
                    next_st.enable = wr_bits;
                end
                `ADCIE_OFF_ENABLE_SET: begin
                    next_st.enable = st.enable | wr_bits;
                end
                `ADCIE_OFF_STATUS_CLR: begin
                    next_clr = wr_bits;
                end
                // unmapped writes fall through and change nothing
                default: begin
                    next_clr = '0;
                end
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                // both views read one shared state
                `ADCIE_OFF_ENABLE,
                `ADCIE_OFF_ENABLE_SET: begin
                    next_st.rdata = {{PAD_W{1'b0}}, st.enable};
                end
                `ADCIE_OFF_STATUS: begin
                    next_st.rdata = {{PAD_W{1'b0}}, evt_bus.status};
                end
                // clear register is write-only; unmapped reads give zero
                default: begin
                    next_st.rdata = `ADCIE_RDATA_RST;
                end
            endcase
        end
        // a cleared enable masks its event
        // registered so the pin never glitches; costs one cycle of latency
        next_st.irq = |(evt_bus.status & st.enable);
    end

    assign evt_bus.evt = i_event;
    assign evt_bus.clr = next_clr;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st.enable <= `ADCIE_ENABLE_RST;
            st.irq <= 1'b0;
            st.rdata <= `ADCIE_RDATA_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_irq = st.irq;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_plain_wr;
        i_wr && (i_addr == `ADCIE_OFF_ENABLE);
    endsequence

    sequence s_set_wr;
        i_wr && (i_addr == `ADCIE_OFF_ENABLE_SET);
    endsequence

    a_ch6_limit_en: assert property (
        s_plain_wr |=> (st.enable[`ADCIE_BIT_CH6_LOWER:`ADCIE_BIT_CH6_UPPER]
            == $past(i_wdata[`ADCIE_BIT_CH6_LOWER:`ADCIE_BIT_CH6_UPPER])))
        else $error("channel 6 limit enables not written");

    a_ch7_limit_en: assert property (
        s_plain_wr ##1 (i_rd && (i_addr == `ADCIE_OFF_ENABLE))
        |=> (o_rdata[`ADCIE_BIT_CH7_LOWER:`ADCIE_BIT_CH7_UPPER]
            == $past(i_wdata[`ADCIE_BIT_CH7_LOWER:`ADCIE_BIT_CH7_UPPER], 2)))
        else $error("channel 7 limit enables not read back");

    a_set_read_back: assert property (
        (i_rd && (i_addr == `ADCIE_OFF_ENABLE_SET))
        |=> (o_rdata == {{PAD_W{1'b0}}, $past(st.enable)}))
        else $error("set register read does not show enables");

    a_low_set_bits: assert property (
        s_set_wr |=> ((st.enable[`ADCIE_BIT_STOPPED:`ADCIE_BIT_STARTED]
            | ~$past(i_wdata[`ADCIE_BIT_STOPPED:`ADCIE_BIT_STARTED])) == 6'h3f))
        else $error("low event enable not set");

    a_ch0_upper_set: assert property (
        (i_wr && (i_addr == `ADCIE_OFF_ENABLE_SET) && i_wdata[`ADCIE_BIT_CH0_UPPER])
        |=> st.enable[`ADCIE_BIT_CH0_UPPER])
        else $error("channel 0 upper enable not set");

    a_plain_read: assert property (
        (i_rd && (i_addr == `ADCIE_OFF_ENABLE))
        |=> (o_rdata == {{PAD_W{1'b0}}, $past(st.enable)}))
        else $error("plain register read does not show enables");

    a_zero_keeps_en: assert property (
        s_set_wr |=> ((st.enable & ~$past(wr_bits)) == ($past(st.enable) & ~$past(wr_bits))))
        else $error("set register write of zero changed an enable");

    a_irq_follows: assert property (
        ((evt_bus.status & st.enable) != '0) |=> o_irq)
        else $error("interrupt not raised for enabled status");

    a_rdata_idle: assert property (
        !i_rd |=> (o_rdata == '0))
        else $error("read data stands outside its cycle");

    a_set_never_clears: assert property (
        s_set_wr |=> (($past(st.enable) & ~st.enable) == '0))
        else $error("set register write cleared an enable");

    a_plain_replaces: assert property (
        s_plain_wr |=> (st.enable == $past(wr_bits)))
        else $error("plain register write did not replace enables");

    a_plain_low_bits: assert property (
        s_plain_wr |=> (st.enable[`ADCIE_BIT_STOPPED:`ADCIE_BIT_STARTED]
            == $past(i_wdata[`ADCIE_BIT_STOPPED:`ADCIE_BIT_STARTED])))
        else $error("plain register low event enables not written");

    a_enable_holds: assert property (
        !(i_wr && ((i_addr == `ADCIE_OFF_ENABLE) || (i_addr == `ADCIE_OFF_ENABLE_SET)))
        |=> $stable(st.enable))
        else $error("enables moved without a register write");

    a_rst_clears: assert property (
        $rose(i_arst_n) |-> ((st.enable == '0) && (o_rdata == '0) && !o_irq))
        else $error("state not cleared after reset");

    a_irq_masked: assert property (
        ((evt_bus.status & st.enable) == '0) |=> !o_irq)
        else $error("interrupt raised with no enabled status");

    a_ch6_irq_gate: assert property (
        ((evt_bus.status[`ADCIE_BIT_CH6_LOWER:`ADCIE_BIT_CH6_UPPER]
            & st.enable[`ADCIE_BIT_CH6_LOWER:`ADCIE_BIT_CH6_UPPER]) != '0) |=> o_irq)
        else $error("channel 6 limit event did not interrupt");

    a_ch7_irq_gate: assert property (
        ((evt_bus.status[`ADCIE_BIT_CH7_LOWER:`ADCIE_BIT_CH7_UPPER]
            & st.enable[`ADCIE_BIT_CH7_LOWER:`ADCIE_BIT_CH7_UPPER]) != '0) |=> o_irq)
        else $error("channel 7 limit event did not interrupt");

    a_low_irq_gate: assert property (
        ((evt_bus.status[`ADCIE_BIT_STOPPED:`ADCIE_BIT_STARTED]
            & st.enable[`ADCIE_BIT_STOPPED:`ADCIE_BIT_STARTED]) != '0) |=> o_irq)
        else $error("low event did not interrupt");

    a_status_read: assert property (
        (i_rd && (i_addr == `ADCIE_OFF_STATUS))
        |=> (o_rdata == {{PAD_W{1'b0}}, $past(evt_bus.status)}))
        else $error("status read does not show sticky bits");

    a_clr_reads_zero: assert property (
        (i_rd && (i_addr == `ADCIE_OFF_STATUS_CLR)) |=> (o_rdata == '0))
        else $error("clear register read is not zero");

    a_rdata_pad_zero: assert property (
        o_rdata[`ADCIE_DATA_W-1:`ADCIE_NUM_EVENTS] == '0)
        else $error("unused read data bits not zero");

    for (genvar g = 0; g < `ADCIE_NUM_EVENTS; g++) begin : g_set_field
        a_set_field: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
            (i_wr && (i_addr == `ADCIE_OFF_ENABLE_SET) && i_wdata[g]) |=> st.enable[g])
            else $error("set register field did not enable its event");
    end

    c_plain_write: cover property (s_plain_wr ##1 (st.enable != '0));
    c_set_then_read: cover property (s_set_wr ##1 (i_rd && (i_addr == `ADCIE_OFF_ENABLE)));
    c_irq_raised: cover property ($rose(o_irq));
    c_event_and_clear: cover property ((evt_bus.evt & evt_bus.clr) != '0);
    c_write_then_read: cover property (s_plain_wr ##1 (i_rd && (i_addr == `ADCIE_OFF_ENABLE)));

endmodule

// File: tb_adcie_enable_regs.sv
// self-checking testbench for the converter interrupt enable bank
`timescale 1ns/1ps
`include "adcie_cfg.svh"

module tb_adcie_enable_regs;
    logic i_sys_clk;
    logic i_arst_n;
    logic [`ADCIE_ADDR_W-1:0] i_addr;
    logic [`ADCIE_DATA_W-1:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [`ADCIE_DATA_W-1:0] o_rdata;
    logic [`ADCIE_NUM_EVENTS-1:0] i_event;
    logic o_irq;
    int n_errors;
    int check_count;
    logic [31:0] exp_en;

    adcie_enable_regs dut (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_event(i_event),
        .o_irq(o_irq)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        chk(o_rdata, exp);
    endtask

    // pulse one event, then look at the irq two edges later
    task automatic evt(input int b, input logic exp_irq);
        @(posedge i_sys_clk);
        i_event <= 22'h1 << b;
        @(posedge i_sys_clk);
        i_event <= 22'h0;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk({31'h0, o_irq}, {31'h0, exp_irq});
    endtask

    task automatic clr_all();
        wr(`ADCIE_OFF_STATUS_CLR, 32'h003fffff);
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk({31'h0, o_irq}, 32'h0);
    endtask

    // write then read in the very next cycle, no idle between
    task automatic wr_rd(input logic [11:0] wa, input logic [31:0] d, input logic [11:0] ra,
        input logic [31:0] exp);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= wa;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= ra;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        chk(o_rdata, exp);
    endtask

    // event pulse in the same cycle as a clear of every status bit
    task automatic evt_clr(input int b);
        @(posedge i_sys_clk);
        i_event <= 22'h1 << b;
        i_wr <= 1'b1;
        i_addr <= `ADCIE_OFF_STATUS_CLR;
        i_wdata <= 32'h003fffff;
        @(posedge i_sys_clk);
        i_event <= 22'h0;
        i_wr <= 1'b0;
    endtask

    task automatic results();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        n_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        results();
    end

    initial begin
        i_arst_n = 1'b0;
        i_addr = 12'h0;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_event = 22'h0;
        n_errors = 0;
        check_count = 0;
        repeat (6) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        rd(`ADCIE_OFF_ENABLE, 32'h0);
        rd(`ADCIE_OFF_ENABLE_SET, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        // upper bits ignored, full write replaces
        wr(`ADCIE_OFF_ENABLE, 32'hffffffff);
        rd(`ADCIE_OFF_ENABLE, 32'h003fffff);
        wr(`ADCIE_OFF_ENABLE, 32'h0);
        rd(`ADCIE_OFF_ENABLE_SET, 32'h0);
        // channel 6 and 7 limits: only the matching enable raises irq
        for (int b = 18; b <= 21; b++) begin
            wr(`ADCIE_OFF_ENABLE, 32'h1 << b);
            evt(b ^ 1, 1'b0);
            rd(`ADCIE_OFF_STATUS, 32'h1 << (b ^ 1));
            evt(b, 1'b1);
            clr_all();
        end
        // back-to-back write and read, then an event racing a clear
        wr_rd(`ADCIE_OFF_ENABLE, 32'h00300000, `ADCIE_OFF_ENABLE, 32'h00300000);
        wr_rd(`ADCIE_OFF_ENABLE_SET, 32'h00040000, `ADCIE_OFF_ENABLE, 32'h00340000);
        evt_clr(2);
        rd(`ADCIE_OFF_STATUS, 32'h4);
        clr_all();
        // set view, one field at a time, seen through both views and irq
        for (int b = 0; b <= 6; b++) begin
            wr(`ADCIE_OFF_ENABLE, 32'h0);
            wr(`ADCIE_OFF_ENABLE_SET, 32'h1 << b);
            rd(`ADCIE_OFF_ENABLE_SET, 32'h1 << b);
            rd(`ADCIE_OFF_ENABLE, 32'h1 << b);
            evt(b, 1'b1);
            clr_all();
        end
        // set accumulates, zeros leave enables alone
        exp_en = 32'h0;
        wr(`ADCIE_OFF_ENABLE, 32'h0);
        for (int b = 0; b <= 6; b++) begin
            exp_en = exp_en | (32'h1 << b);
            wr(`ADCIE_OFF_ENABLE_SET, 32'h1 << b);
            rd(`ADCIE_OFF_ENABLE_SET, exp_en);
        end
        wr(`ADCIE_OFF_ENABLE_SET, 32'h0);
        rd(`ADCIE_OFF_ENABLE, exp_en);
        wr(`ADCIE_OFF_ENABLE_SET, 32'h00300000);
        rd(`ADCIE_OFF_ENABLE, exp_en | 32'h00300000);
        // unmapped read answers zero
        rd(12'h308, 32'h0);
        wr(12'h308, 32'h003fffff);
        rd(`ADCIE_OFF_ENABLE, exp_en | 32'h00300000);
        rd(`ADCIE_OFF_STATUS_CLR, 32'h0);
        evt(0, 1'b1);
        // reset in mid-run clears enables
        @(posedge i_sys_clk);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        rd(`ADCIE_OFF_ENABLE_SET, 32'h0);
        rd(`ADCIE_OFF_STATUS, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        results();
    end
endmodule
